// >>> uart_msr_baud_pkg.sv
// Package for the modem status, scratch and baud generator block.
// Assumes a 32-bit word-addressed register port; offsets are byte addresses.
package uart_msr_baud_pkg;
  localparam logic [31:0] ADDR_MODEM_STATUS    = 32'h40005018;
  localparam logic [31:0] ADDR_SCRATCH_BYTE    = 32'h4000501C;
  localparam logic [31:0] ADDR_IRQ_STATUS      = 32'h40005020;
  localparam logic [31:0] ADDR_FRACTIONAL_BAUD = 32'h40005024;
  localparam logic [31:0] ADDR_BAUD_DIVIDER    = 32'h40005028;
  localparam logic [31:0] ADDR_IRQ_MASK        = 32'h4000502C;
  localparam logic [31:0] ADDR_CLOCK_DIVIDER   = 32'h40005030;

  localparam logic [15:0] RST_MODEM_STATUS    = 16'h0000;
  localparam logic [15:0] RST_SCRATCH_BYTE    = 16'h0000;
  localparam logic [15:0] RST_FRACTIONAL_BAUD = 16'h0000;
  localparam logic [15:0] RST_BAUD_DIVIDER    = 16'h0001;
  localparam logic [7:0]  RST_CLOCK_DIVIDER   = 8'h01;
  localparam logic [3:0]  RST_IRQ             = 4'h0;

  localparam int BIT_CARRIER   = 7;
  localparam int BIT_RING      = 6;
  localparam int BIT_DSR       = 5;
  localparam int BIT_CTS       = 4;
  localparam int BIT_DCD_CHG   = 3;
  localparam int BIT_RING_EDGE = 2;
  localparam int BIT_DSR_CHG   = 1;
  localparam int BIT_CTS_CHG   = 0;
  localparam int BIT_FRAC_EN   = 15;
  localparam int FRAC_M_HI     = 12;
  localparam int FRAC_M_LO     = 11;
  localparam int FRAC_N_HI     = 10;
  localparam int FRAC_N_W      = 11;
  localparam int OVERSAMPLE    = 16;
  localparam logic [4:0] OVERSAMPLE_LAST = 5'h0F;
endpackage

// >>> uart_msr_baud.sv
// Modem status register, scratch register and fractional baud generator.
// Assumes pin inputs are already synchronous to mclk_i; single clock domain.
//
// Behaviour
// - Status bit 7 reads as the inverse of the carrier detect pin.
// - Status bit 6 reads as the inverse of the ring indicator pin.
// - Status bit 5 reads as the inverse of the data set ready pin.
// - Status bit 4 reads as the inverse of the clear to send pin.
// - Bit 3 sets on any carrier detect change and clears after a status read.
// - Bit 2 sets when ring status goes 0 to 1 and clears after a status read.
// - Bit 1 sets on any data set ready change and clears after a status read.
// - Bit 0 sets on any clear to send change and clears after a status read.
// - Status bits 15 to 8 read as zero.
// - The scratch register stores 8 bits and returns the last value written.
// - Scratch upper bits read zero and the scratch value steers nothing.
// - Fractional baud bit 15 turns on the fractional generator.
// - Fractional rate is clock over divider over 2(M+N/2048) over 16 times divisor.
// - The N field sits at bits 10:0 and takes 0 to 2047.
`timescale 1ns/1ns
module uart_msr_baud
  import uart_msr_baud_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic        carrier_detect_pin_n_i,
  input  wire logic        ring_indicator_pin_n_i,
  input  wire logic        data_set_ready_pin_n_i,
  input  wire logic        clear_to_send_pin_n_i,
  output logic      [31:0] rdata_o,
  output logic             baud_tick_o,
  output logic             oversample_tick_o,
  output logic      [3:0]  modem_change_o,
  output logic             irq_o
);

  logic [3:0]  pin_level;       // Inverted pins: carrier, ring, dsr, cts
  logic [3:0]  pin_prev;
  logic [3:0]  change_flags;    // carrier_detect_changed .. clear_to_send_changed
  logic [3:0]  next_change;
  logic [3:0]  change_event;
  logic [7:0]  scratch_value;
  logic        fractional_enable;
  logic [1:0]  fractional_m_field;
  logic [10:0] fractional_n_field;
  logic [15:0] baud_divider;
  logic [7:0]  peripheral_clock_divider;
  logic [3:0]  irq_status;
  logic [3:0]  irq_mask;
  logic [3:0]  next_irq_status;
  logic        read_status;
  logic [7:0]  pclk_cnt;
  logic        pclk_tick;
  logic [1:0]  m_cnt;
  logic [11:0] n_acc;
  logic        extra_cycle;
  logic        frac_tick;
  logic [15:0] div_cnt;
  logic        os_tick;
  logic [4:0]  os_cnt;
  logic        seen;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] ref_addr);
    hit = (a == ref_addr);
  endfunction

  // Status bits are the complement of the active-low pins
  assign pin_level = {~carrier_detect_pin_n_i,
                      ~ring_indicator_pin_n_i,
                      ~data_set_ready_pin_n_i,
                      ~clear_to_send_pin_n_i};

  // Change events; ring only counts a rise of its status bit
  assign change_event = {pin_level[3] ^ pin_prev[3],
                         pin_level[2] & ~pin_prev[2],
                         pin_level[1] ^ pin_prev[1],
                         pin_level[0] ^ pin_prev[0]};

  // Status read strobe; the same decode feeds the flag clear and the read mux.
  // A read clears all four change flags at once, so software that wants
  // to see every change must read often enough not to miss a second one.
  // Back to back reads are fine: the second sees only changes since the first.
  assign read_status = rd_i && hit(addr_i, ADDR_MODEM_STATUS);

  // Set wins over the read clear so an edge in the read cycle is kept.
  // Hazard: a pin that toggles in the very read cycle shows up on the next
  // read, never lost and never reported twice.
  // Flag order, high to low: carrier, ring rise, data set ready, clear to send.
  // The ring flag only counts a status rise, i.e. the pin going low.
  always_comb begin
    next_change = change_flags;
    if (read_status) begin
      next_change = 4'h0;
    end
    next_change = next_change | change_event;
  end

  // Pin history; seen avoids a false change flag on the first cycle after reset.
  // History resets to the idle status (all pins high, status zero), so a
  // pin already low when reset ends shows a change only in the first cycle,
  // while seen is clear; no flag is raised, but modem_change_o still pulses for that cycle.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pin_prev <= 4'h0;
      seen     <= 1'b0;
    end else begin
      pin_prev <= pin_level;
      seen     <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      change_flags <= RST_MODEM_STATUS[3:0];
    end else if (seen) begin
      change_flags <= next_change;
    end else begin
      change_flags <= 4'h0;
    end
  end

  // Register writes.
  // Layouts, all in the low half word of the data bus:
  //   scratch_byte     [7:0]  free storage, steers nothing
  //   fractional_baud  [15]   fractional generator on
  //                    [12:11] M field, software keeps it 1 to 3
  //                    [10:0] N field, 0 to 2047
  //   baud_divider     [15:0] integer divisor, software keeps it nonzero
  //   clock divider    [7:0]  peripheral clock divide, zero acts as one
  //   interrupt mask   [3:0]  same order as the change flags
  // Reserved fields are not stored, so they read back as zero for free.
  // Writes to the status register are ignored; its flags clear by reading.
  // Limitation: changing a divider mid period applies at once to the count in progress,
  // so the first baud period after a write may be of mixed length.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      scratch_value            <= RST_SCRATCH_BYTE[7:0];
      fractional_enable        <= RST_FRACTIONAL_BAUD[BIT_FRAC_EN];
      fractional_m_field       <= RST_FRACTIONAL_BAUD[FRAC_M_HI:FRAC_M_LO];
      fractional_n_field       <= RST_FRACTIONAL_BAUD[FRAC_N_HI:0];
      baud_divider             <= RST_BAUD_DIVIDER;
      peripheral_clock_divider <= RST_CLOCK_DIVIDER;
      irq_mask                 <= RST_IRQ;
    end else if (wr_i) begin
      if (hit(addr_i, ADDR_SCRATCH_BYTE)) begin
        scratch_value <= wdata_i[7:0];
      end
      if (hit(addr_i, ADDR_FRACTIONAL_BAUD)) begin
        fractional_enable  <= wdata_i[BIT_FRAC_EN];
        fractional_m_field <= wdata_i[FRAC_M_HI:FRAC_M_LO];
        fractional_n_field <= wdata_i[FRAC_N_HI:0];
      end
      if (hit(addr_i, ADDR_BAUD_DIVIDER)) begin
        baud_divider <= wdata_i[15:0];
      end
      if (hit(addr_i, ADDR_CLOCK_DIVIDER)) begin
        peripheral_clock_divider <= wdata_i[7:0];
      end
      if (hit(addr_i, ADDR_IRQ_MASK)) begin
        irq_mask <= wdata_i[3:0];
      end
    end
  end

  // Interrupt status: sticky, write one to clear, new event wins.
  // Kept apart from the status flags so a status read does not drop a
  // pending interrupt; software clears it here explicitly.
  // The output is registered from the next state so it rises in the same
  // cycle as the sticky bit, not one cycle behind.
  always_comb begin
    next_irq_status = irq_status;
    if (wr_i && hit(addr_i, ADDR_IRQ_STATUS)) begin
      next_irq_status = next_irq_status & ~wdata_i[3:0];
    end
    next_irq_status = next_irq_status | (change_event & {4{seen}});
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      irq_status <= RST_IRQ;
      irq_o      <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_o      <= |(next_irq_status & irq_mask);
    end
  end

  // Read data one cycle after the strobe; unmapped and reserved bits read zero.
  // The bus returns zero whenever no read was asked, so a stale value can
  // never be mistaken for a fresh answer.
  // The status read returns the flags as they stood before this read clears
  // them; a change in the read cycle itself waits for the next read.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      if (hit(addr_i, ADDR_MODEM_STATUS)) begin
        rdata_o <= {24'h000000, pin_level, change_flags};
      end else if (hit(addr_i, ADDR_SCRATCH_BYTE)) begin
        rdata_o <= {24'h000000, scratch_value};
      end else if (hit(addr_i, ADDR_FRACTIONAL_BAUD)) begin
        rdata_o <= {16'h0000, fractional_enable, 2'b00, fractional_m_field,
                    fractional_n_field};
      end else if (hit(addr_i, ADDR_BAUD_DIVIDER)) begin
        rdata_o <= {16'h0000, baud_divider};
      end else if (hit(addr_i, ADDR_IRQ_STATUS)) begin
        rdata_o <= {28'h0000000, irq_status};
      end else if (hit(addr_i, ADDR_IRQ_MASK)) begin
        rdata_o <= {28'h0000000, irq_mask};
      end else if (hit(addr_i, ADDR_CLOCK_DIVIDER)) begin
        rdata_o <= {24'h000000, peripheral_clock_divider};
      end else begin
        rdata_o <= 32'h00000000;
      end
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      modem_change_o <= 4'h0;
    end else begin
      modem_change_o <= next_change;
    end
  end

  // Registered copy of the change flags for the line status side.
  // It follows the next state so a new change is visible one edge after it.
  // Peripheral clock divider; zero treated as one.
  // With a divide of one the tick is high every cycle, which is the
  // reset setting; the later stages only ever look at this tick.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      pclk_cnt  <= 8'h00;
      pclk_tick <= 1'b0;
    end else if (pclk_cnt + 8'h01 >= peripheral_clock_divider) begin
      pclk_cnt  <= 8'h00;
      pclk_tick <= 1'b1;
    end else begin
      pclk_cnt  <= pclk_cnt + 8'h01;
      pclk_tick <= 1'b0;
    end
  end

  // Fractional stage: period of 2*M ticks, plus one every time N/2048 carries.
  // Average period 2*(M+N/2048); jitter of one tick is the trade for no divider.
  // Off: M forced to 1, N to 0, giving a steady divide by 2.
  // The down counter is loaded with M minus one, so a half period lasts
  // exactly M ticks; M of zero wraps to four ticks, which software avoids.
  // The accumulator holds the running fraction; its top bit is the carry
  // that asks for one stretched half period.
  // The carry is spent at the wrap point before the next half period is
  // started, so it lengthens that half by exactly one peripheral tick.
  // Over many periods the average is exact; only single periods jitter.
  assign extra_cycle = fractional_enable & n_acc[FRAC_N_W];

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      m_cnt     <= 2'b00;
      n_acc     <= 12'h000;
      frac_tick <= 1'b0;
    end else begin
      frac_tick <= 1'b0;
      if (pclk_tick) begin
        if (m_cnt == 2'b00) begin
          // Half periods of M ticks each; the carry adds one pclk tick
          if (extra_cycle) begin
            n_acc <= {1'b0, n_acc[FRAC_N_W-1:0]};
          end else begin
            m_cnt     <= fractional_enable ? (fractional_m_field - 2'b01) : 2'b00;
            frac_tick <= 1'b1;
            if (fractional_enable) begin
              n_acc <= {1'b0, n_acc[FRAC_N_W-1:0]} + {1'b0, fractional_n_field};
            end
          end
        end else begin
          m_cnt <= m_cnt - 2'b01;
        end
      end
    end
  end

  // Half-period pulses pair into one full period of the 2x stage.
  // This is the factor of two in the rate; pairing rather than a second
  // counter keeps the fraction spread over both halves.
  logic half;
  logic frac_out;
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      half     <= 1'b0;
      frac_out <= 1'b0;
    end else begin
      frac_out <= frac_tick & half;
      if (frac_tick) begin
        half <= ~half;
      end
    end
  end

  // Integer divider then 16x oversampling; divisor 0 behaves as 1.
  // The compare is on count plus one, so a divisor of one passes every
  // pulse and a divisor of zero cannot stall the chain.
  // Each pass here is one oversample tick for the receive sampler.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      div_cnt <= 16'h0000;
      os_tick <= 1'b0;
    end else begin
      os_tick <= 1'b0;
      if (frac_out) begin
        if (div_cnt + 16'h0001 >= baud_divider) begin
          div_cnt <= 16'h0000;
          os_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 16'h0001;
        end
      end
    end
  end

  // Sixteen oversample ticks make one baud tick; both outputs are
  // registered here so they line up in the same cycle on the wrap.
  // The receive side can use the oversample tick to find bit centres,
  // the transmit side the baud tick to shift out one bit.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      os_cnt            <= 5'h00;
      oversample_tick_o <= 1'b0;
      baud_tick_o       <= 1'b0;
    end else begin
      oversample_tick_o <= os_tick;
      baud_tick_o       <= 1'b0;
      if (os_tick) begin
        if (os_cnt == OVERSAMPLE_LAST) begin
          os_cnt      <= 5'h00;
          baud_tick_o <= 1'b1;
        end else begin
          os_cnt <= os_cnt + 5'h01;
        end
      end
    end
  end

endmodule

// >>> uart_msr_baud_assertions.sv
// Checker for the modem status, scratch and baud block, bound to its top.
// Assumes pins stay steady for a cycle around every status read.
`timescale 1ns/1ns
module uart_msr_baud_chk
  import uart_msr_baud_pkg::*;
(
  input logic        mclk_i,
  input logic        srst_i,
  input logic [31:0] addr_i,
  input logic        rd_i,
  input logic        carrier_detect_pin_n_i,
  input logic        ring_indicator_pin_n_i,
  input logic        data_set_ready_pin_n_i,
  input logic        clear_to_send_pin_n_i,
  input logic [31:0] rdata_o,
  input logic [3:0]  modem_change_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  logic rd_ms;
  // Status read decode, shared by the pin checks
  assign rd_ms = rd_i && addr_i == ADDR_MODEM_STATUS;
  property p_carrier; rd_ms |=> rdata_o[7] == !$past(carrier_detect_pin_n_i); endproperty
  a_carrier: assert property (p_carrier) else $error("carrier bit wrong");
  property p_pins;
    rd_ms |=> rdata_o[6:4] == ~{$past(ring_indicator_pin_n_i),
      $past(data_set_ready_pin_n_i), $past(clear_to_send_pin_n_i)};
  endproperty
  a_pins: assert property (p_pins) else $error("pin status bits wrong");
  property p_rsvd; rd_ms |=> rdata_o[31:8] == 24'h000000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("status upper bits set");
  property p_scr; rd_i && addr_i == ADDR_SCRATCH_BYTE |=> rdata_o[31:8] == 24'h000000; endproperty
  a_scr: assert property (p_scr) else $error("scratch upper bits set");
  // Flag copy is registered, so allow up to two edges
  property p_dcd; $changed(carrier_detect_pin_n_i) |-> ##[1:2] modem_change_o[3]; endproperty
  a_dcd: assert property (p_dcd) else $error("carrier change missed");
  property p_ring; $fell(ring_indicator_pin_n_i) |-> ##[1:2] modem_change_o[2]; endproperty
  a_ring: assert property (p_ring) else $error("ring edge missed");
  property p_dsr; $changed(data_set_ready_pin_n_i) |-> ##[1:2] modem_change_o[1]; endproperty
  a_dsr: assert property (p_dsr) else $error("dsr change missed");
  property p_cts; $changed(clear_to_send_pin_n_i) |-> ##[1:2] modem_change_o[0]; endproperty
  a_cts: assert property (p_cts) else $error("cts change missed");
endmodule

bind uart_msr_baud uart_msr_baud_chk u_chk (.*);

// >>> uart_msr_baud_modem.sv
// Remote modem model driving the four active-low status pins.
// Assumes the pins are launched just after a rising edge of mclk_i.
`timescale 1ns/1ns
module uart_msr_baud_modem (
  input  wire logic       mclk_i,
  output logic      [3:0] pin_n_o
);
  // Idle high: every line inactive until the bench asks otherwise
  initial pin_n_o = 4'hF;
  // Order is carrier, ring, data set ready, clear to send
  task automatic drive(input int j, input logic v);
    @(posedge mclk_i);
    pin_n_o[j] <= v;
  endtask
endmodule

// >>> uart_msr_baud_tb.sv
// Self-checking bench for the modem status, scratch and baud block.
// Assumes the register port answers reads one cycle later, no waits.
`timescale 1ns/1ns
module uart_msr_baud_tb;
  import uart_msr_baud_pkg::*;
  logic            mclk_i  = 1'b0;
  logic            srst_i  = 1'b1;
  logic            wr_i    = 1'b0;
  logic            rd_i    = 1'b0;
  logic     [31:0] addr_i  = 32'h00000000;
  logic     [31:0] wdata_i = 32'h00000000;
  wire logic [3:0] pin_n;
  logic     [31:0] rdata_o;
  logic     [31:0] d;
  logic      [3:0] modem_change_o;
  logic            baud_tick_o;
  logic            oversample_tick_o;
  logic            irq_o;
  int              fails = 0;
  int              n_checks = 0;

  uart_msr_baud u_dut (.mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .carrier_detect_pin_n_i(pin_n[3]),
    .ring_indicator_pin_n_i(pin_n[2]), .data_set_ready_pin_n_i(pin_n[1]),
    .clear_to_send_pin_n_i(pin_n[0]), .rdata_o(rdata_o), .baud_tick_o(baud_tick_o),
    .oversample_tick_o(oversample_tick_o), .modem_change_o(modem_change_o), .irq_o(irq_o));
  uart_msr_baud_modem u_modem (.mclk_i(mclk_i), .pin_n_o(pin_n));

  // Free running 100 MHz clock
  initial forever #5 mclk_i = ~mclk_i;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a; wdata_i <= v; wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    addr_i <= a; rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
    chk(d, exp);
  endtask
  // Cycles over n baud periods, plus oversample ticks seen in them
  task automatic baud(input int n, input int exp);
    int c, k, o;
    for (k = 0; k < 2; k++) begin
      c = 0;
      do begin @(negedge mclk_i); c++; end while (baud_tick_o !== 1'b1 && c < 20000);
    end
    c = 0; k = 0; o = 0;
    do begin
      @(negedge mclk_i);
      c++;
      o += (oversample_tick_o === 1'b1);
      k += (baud_tick_o === 1'b1);
    end while (k < n && c < 20000);
    chk(c, exp);
    chk(o, 16 * n);
  endtask

  task automatic t_reset;
    rchk(ADDR_MODEM_STATUS, 32'h0000);
    rchk(ADDR_SCRATCH_BYTE, 32'h0000);
    rchk(ADDR_FRACTIONAL_BAUD, 32'h0000);
    rchk(ADDR_BAUD_DIVIDER, 32'h0001);
    rchk(32'h40005000, 32'h0000);
    $display("reset values done");
  endtask
  task automatic t_scratch;
    wr(ADDR_SCRATCH_BYTE, 32'hFFFFFFA5);
    rchk(ADDR_SCRATCH_BYTE, 32'h00A5);
    wr(ADDR_SCRATCH_BYTE, 32'h00FF);
    rchk(ADDR_SCRATCH_BYTE, 32'h00FF);
    $display("scratch done");
  endtask
  // Each pin falls then rises; only ring ignores the rising edge
  task automatic t_modem;
    for (int j = 3; j >= 0; j--) begin
      u_modem.drive(j, 1'b0);
      wt(4);
      chk({28'h0, modem_change_o}, 32'h1 << j);
      rchk(ADDR_MODEM_STATUS, 32'h11 << j);
      rchk(ADDR_MODEM_STATUS, 32'h10 << j);
      u_modem.drive(j, 1'b1);
      wt(4);
      rchk(ADDR_MODEM_STATUS, (j == 2) ? 32'h0 : 32'h1 << j);
      rchk(ADDR_MODEM_STATUS, 32'h0000);
    end
    $display("modem status done");
  endtask
  task automatic t_irq;
    wr(ADDR_IRQ_STATUS, 32'hF);
    wr(ADDR_IRQ_MASK, 32'h1);
    u_modem.drive(0, 1'b0);
    wt(4);
    chk({31'h0, irq_o}, 32'h1);
    rchk(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h1);
    wt(3);
    chk({31'h0, irq_o}, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h0);
    u_modem.drive(0, 1'b1);
    wt(4);
    chk({31'h0, irq_o}, 32'h0);
    rchk(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_MASK, 32'h1);
    wt(3);
    chk({31'h0, irq_o}, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_MASK, 32'h0);
    $display("interrupt done");
  endtask
  // Scratch still holds FF here, so any leak into the rate shows
  task automatic t_baud;
    baud(1, 32);
    wr(ADDR_BAUD_DIVIDER, 32'h0003);
    baud(1, 96);
    wr(ADDR_FRACTIONAL_BAUD, 32'h9000);
    baud(1, 192);
    wr(ADDR_FRACTIONAL_BAUD, 32'h8C00);
    rchk(ADDR_FRACTIONAL_BAUD, 32'h8C00);
    baud(4, 576);
    rchk(ADDR_BAUD_DIVIDER, 32'h0003);
    wr(ADDR_CLOCK_DIVIDER, 32'h0002);
    rchk(ADDR_CLOCK_DIVIDER, 32'h0002);
    baud(2, 576);
    $display("baud done");
  endtask

  task automatic print_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Main sequence after 12 cycles of reset
  initial begin
    repeat (12) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_reset;
    t_scratch;
    t_modem;
    t_irq;
    t_baud;
    print_verdict;
  end
  // Watchdog well past the few thousand cycles the tests need
  initial begin
    #300000;
    fails++;
    print_verdict;
  end
endmodule
